// [core/phase_mgr.sv]
// Digital phase manager of a dual-output seven-phase PWM controller.
// Assumes one 200 MHz clock; current, error and edge inputs come from
// logic on the same clock; strap pins are asynchronous.
//
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "phase_mgr_defs.svh"
module phase_mgr (
  input  wire logic                   clock_in,
  input  wire logic                   rst_in,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic [3:0]             address_strap_pin,
  input  wire logic [2:0]             config_strap_in,
  input  wire phase_mgr_pkg::pair12_t load_current_in,
  input  wire phase_mgr_pkg::pair12_t sense_temp_in,
  input  wire phase_mgr_pkg::word12_t reg_error_in,
  input  wire logic [1:0][7:0]        lead_adj_in,
  input  wire logic [1:0][7:0]        trail_adj_in,
  input  wire logic [3:0]             margin_sel_in,
  input  wire logic                   avs_valid_in,
  input  wire logic                   avs_rail_in,
  input  wire phase_mgr_pkg::word12_t avs_vout_in,
  output logic [6:0]                  pwm_out,
  output logic [6:0]                  pwm_oe_out,
  output logic [6:0]                  bus_address_out,
  output phase_mgr_pkg::pair12_t      vout_target_out,
  output phase_mgr_pkg::pair12_t      current_report_out
);
  import phase_mgr_pkg::*;

  st_s s_ff;
  st_s nxt_s;

  // Phases of one rail that survive dropping; up=1 keeps the lowest numbers
  function automatic logic [6:0] keep_mask(input logic [6:0] mine, input logic [2:0] cnt,
                                           input logic up);
    logic [2:0] rank;
    int         idx;
    rank = 3'h0;
    keep_mask = 7'h00;
    for (int i = 0; i < `NPH; i++) begin
      idx = up ? i : (`NPH - 1 - i);
      if (mine[idx]) begin
        if (rank < cnt) keep_mask[idx] = 1'b1;
        rank = rank + 3'h1;
      end
    end
  endfunction

  function automatic logic [2:0] ones(input logic [6:0] v);
    ones = 3'h0;
    for (int i = 0; i < `NPH; i++) ones = ones + {2'h0, v[i]};
  endfunction

  // Bounds a requested voltage; min wins if software inverts the limits
  function automatic word12_t clamp(input word12_t v, input word12_t lo, input word12_t hi);
    if (v > hi) clamp = hi;
    else clamp = v;
    if (clamp < lo) clamp = lo;
  endfunction

  // Register read view, shared by the read channel and byte-lane merging
  function automatic logic [31:0] rd_word(input st_s s, input logic [7:0] a);
    case (a)
      `A_CTRL:    rd_word = {28'h0, s.ctrl};
      `A_PERIOD:  rd_word = {22'h0, s.period};
      `A_MAP:     rd_word = {18'h0, s.map};
      `A_STORE:   rd_word = {18'h0, s.nvm[s.cfg_slot]};
      `A_DUTY:    rd_word = {6'h0, s.duty[1], 6'h0, s.duty[0]};
      `A_ADDTHR:  rd_word = {4'h0, s.add_thr[1], 4'h0, s.add_thr[0]};
      `A_DROPTHR: rd_word = {4'h0, s.drop_thr[1], 4'h0, s.drop_thr[0]};
      `A_DROPDLY: rd_word = {8'h0, s.drop_dly};
      `A_FASTTHR: rd_word = {20'h0, s.fast_thr};
      `A_REFRESH: rd_word = {8'h0, s.refresh};
      `A_VCMD:    rd_word = {4'h0, s.vcmd[1], 4'h0, s.vcmd[0]};
      `A_VMH:     rd_word = {4'h0, s.vmh[1], 4'h0, s.vmh[0]};
      `A_VML:     rd_word = {4'h0, s.vml[1], 4'h0, s.vml[0]};
      `A_VMAX:    rd_word = {4'h0, s.vmax[1], 4'h0, s.vmax[0]};
      `A_VMIN:    rd_word = {4'h0, s.vmin[1], 4'h0, s.vmin[0]};
      `A_TCAL:    rd_word = {16'h0, s.tcal};
      `A_STATUS:  rd_word = {14'h0, s.cfg_slot, s.addr, 1'h0, s.act[1], 1'h0, s.act[0]};
      default:    rd_word = 32'h0;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= `A_STATUS) && (a[1:0] == 2'h0);
  endfunction

  logic [6:0]  mine [2];
  logic [6:0]  keep;
  logic [6:0]  drop;
  logic [6:0]  drop_q;
  logic [2:0]  have [2];
  logic [31:0] m;
  logic        wr_go;
  int          tdcr;
  int          corr;
  int          off;
  int          pos;
  int          wid;
  logic [9:0]  per;

  always_comb begin
    nxt_s = s_ff;
    // Strap pins: three stages, a level counts once stages two and three agree
    nxt_s.sa_sync  = {s_ff.sa_sync[1:0], address_strap_pin};
    nxt_s.cfg_sync = {s_ff.cfg_sync[1:0], config_strap_in};
    if (s_ff.boot && s_ff.sa_sync[1] == s_ff.sa_sync[2]
        && s_ff.cfg_sync[1] == s_ff.cfg_sync[2]) begin
      nxt_s.boot     = 1'b0;
      nxt_s.addr     = 7'(`SA_TABLE >> (7 * s_ff.sa_sync[2]));
      nxt_s.cfg_slot = s_ff.cfg_sync[2];
      nxt_s.map      = s_ff.nvm[s_ff.cfg_sync[2]];
    end

    // Rail ownership: map[6:0] enables a phase, map[13:7] gives it to output 1
    mine[0] = s_ff.map[6:0] & ~s_ff.map[13:7] & {7{s_ff.ctrl[0]}};
    mine[1] = s_ff.map[6:0] & s_ff.map[13:7] & {7{s_ff.ctrl[1]}};
    have[0] = ones(mine[0]);
    have[1] = ones(mine[1]);
    keep = keep_mask(mine[0], s_ff.act[0], 1'b1)
         | keep_mask(mine[1], s_ff.act[1], 1'b0);
    drop = (mine[0] | mine[1]) & ~keep;

    // Add/drop per rail on the temperature-corrected current
    for (int r = 0; r < 2; r++) begin
      tdcr = ((int'(s_ff.tcal[7:0]) * int'(sense_temp_in[r])) >>> `SLOPE_SHIFT)
           + int'($signed(s_ff.tcal[15:8]));
      corr = int'(load_current_in[r]);
      if (s_ff.ctrl[3])
        corr = corr - ((corr * (tdcr - `TREF_C)) >>> `TC_SHIFT);
      if (corr < 0) corr = 0;
      if (corr > 32'sh0fff) corr = 32'sh0fff;
      nxt_s.irep[r] = word12_t'(corr);
      if (!s_ff.ctrl[2] || reg_error_in > s_ff.fast_thr) begin
        nxt_s.act[r]  = have[r];
        nxt_s.dtmr[r] = 24'h0;
      end else if (s_ff.act[r] > have[r]) begin
        nxt_s.act[r] = have[r];
      end else if (s_ff.irep[r] > s_ff.add_thr[r] && s_ff.act[r] < have[r]) begin
        nxt_s.act[r]  = s_ff.act[r] + 3'h1;
        nxt_s.dtmr[r] = 24'h0;
      end else if (s_ff.irep[r] < s_ff.drop_thr[r] && s_ff.act[r] > 3'h1) begin
        // Wait counts from the load falling or from the previous drop
        if (s_ff.dtmr[r] >= s_ff.drop_dly) begin
          nxt_s.act[r]  = s_ff.act[r] - 3'h1;
          nxt_s.dtmr[r] = 24'h0;
        end else begin
          nxt_s.dtmr[r] = s_ff.dtmr[r] + 24'h1;
        end
      end else begin
        nxt_s.dtmr[r] = 24'h0;
      end
      if (have[r] != 3'h0 && nxt_s.act[r] == 3'h0) nxt_s.act[r] = 3'h1;
    end

    // Target selection: 0 nominal, 1 margin high, 2 margin low
    for (int r = 0; r < 2; r++) begin
      case (margin_sel_in[2*r +: 2])
        2'h1:    nxt_s.vtgt[r] = clamp(s_ff.vmh[r], s_ff.vmin[r], s_ff.vmax[r]);
        2'h2:    nxt_s.vtgt[r] = clamp(s_ff.vml[r], s_ff.vmin[r], s_ff.vmax[r]);
        default: nxt_s.vtgt[r] = clamp(s_ff.vcmd[r], s_ff.vmin[r], s_ff.vmax[r]);
      endcase
    end

    // Shared frame counter; period held inside the legal frequency range
    per = s_ff.period;
    nxt_s.cnt = (s_ff.cnt >= per - 10'h1) ? 10'h0 : s_ff.cnt + 10'h1;

    // Boot refresh: one shared timer, all dropped phases pulled low together
    if (s_ff.rwin != 8'h0) begin
      nxt_s.rwin = s_ff.rwin - 8'h1;
    end else if (s_ff.rtmr >= s_ff.refresh) begin
      nxt_s.rtmr = 24'h0;
      nxt_s.rwin = `REFRESH_W;
    end else begin
      nxt_s.rtmr = s_ff.rtmr + 24'h1;
    end

    // Dual-edge pulse per phase, slot offset one eighth of the period per phase
    for (int p = 0; p < `NPH; p++) begin
      int rl;
      rl  = (mine[1][p]) ? 1 : 0;
      off = (int'(per) * p) >> 3;
      pos = int'(s_ff.cnt) + int'(lead_adj_in[rl]) - off;
      if (pos < 0) pos = pos + int'(per);
      if (pos >= int'(per)) pos = pos - int'(per);
      wid = int'(s_ff.duty[rl]) + int'(lead_adj_in[rl]) + int'(trail_adj_in[rl]);
      if (wid > int'(per) - 1) wid = int'(per) - 1;
      nxt_s.pwm[p] = keep[p] && (pos < wid);
      nxt_s.oe[p]  = keep[p] || (drop[p] && s_ff.rwin != 8'h0);
    end

    // Register port: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_s.aw_ok = 1'b1;
      nxt_s.awa   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_s.w_ok = 1'b1;
      nxt_s.wd   = s_axi_wdata;
      nxt_s.ws   = s_axi_wstrb;
    end
    if (s_ff.bv && s_axi_bready) nxt_s.bv = 1'b0;
    wr_go = s_ff.aw_ok && s_ff.w_ok;
    m = rd_word(s_ff, s_ff.awa);
    for (int b = 0; b < 4; b++) begin
      if (s_ff.ws[b]) m[8*b +: 8] = s_ff.wd[8*b +: 8];
    end
    if (wr_go) begin
      nxt_s.aw_ok = 1'b0;
      nxt_s.w_ok  = 1'b0;
      nxt_s.bv    = 1'b1;
      nxt_s.br    = mapped(s_ff.awa) ? `RESP_OK : `RESP_SLVERR;
      case (s_ff.awa)
        `A_CTRL:    nxt_s.ctrl = m[3:0];
        `A_PERIOD: begin
          if (m[9:0] < 10'(`PER_MIN)) nxt_s.period = 10'(`PER_MIN);
          else if (m[9:0] > 10'(`PER_MAX)) nxt_s.period = 10'(`PER_MAX);
          else nxt_s.period = m[9:0];
        end
        `A_MAP:     nxt_s.map = m[13:0];
        `A_STORE: begin
          nxt_s.cfg_slot = m[18:16];
          nxt_s.nvm[m[18:16]] = m[13:0];
        end
        `A_DUTY:    nxt_s.duty = {m[25:16], m[9:0]};
        `A_ADDTHR:  nxt_s.add_thr = {m[27:16], m[11:0]};
        `A_DROPTHR: nxt_s.drop_thr = {m[27:16], m[11:0]};
        `A_DROPDLY: nxt_s.drop_dly = m[23:0];
        `A_FASTTHR: nxt_s.fast_thr = m[11:0];
        `A_REFRESH: nxt_s.refresh = m[23:0];
        `A_VCMD:    nxt_s.vcmd = {m[27:16], m[11:0]};
        `A_VMH:     nxt_s.vmh = {m[27:16], m[11:0]};
        `A_VML:     nxt_s.vml = {m[27:16], m[11:0]};
        `A_VMAX:    nxt_s.vmax = {m[27:16], m[11:0]};
        `A_VMIN:    nxt_s.vmin = {m[27:16], m[11:0]};
        `A_TCAL:    nxt_s.tcal = m[15:0];
        default:    nxt_s.br = `RESP_SLVERR;
      endcase
    end
    // Fast voltage port lands after the bus so it wins a same-cycle clash
    if (avs_valid_in) nxt_s.vcmd[avs_rail_in] = avs_vout_in;

    if (s_ff.rv && s_axi_rready) nxt_s.rv = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_s.rv = 1'b1;
      nxt_s.rd = rd_word(s_ff, s_axi_araddr);
      nxt_s.rr = mapped(s_axi_araddr) ? `RESP_OK : `RESP_SLVERR;
    end
  end

  // One register for the whole state; nonvolatile slots restart on defaults
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      s_ff          <= '0;
      s_ff.boot     <= 1'b1;
      s_ff.nvm      <= {8{`MAP_RST}};
      s_ff.map      <= `MAP_RST;
      s_ff.ctrl     <= 4'h1;
      s_ff.period   <= `PER_RST;
      s_ff.drop_dly <= `DLY_RST;
      s_ff.refresh  <= `REF_RST;
      s_ff.vmax     <= {2{`VMAX_RST}};
      s_ff.fast_thr <= `VMAX_RST;
      s_ff.act      <= {3'h0, 3'h7};
      // Strap stages keep sampling in reset so no stale zero is taken at release
      s_ff.sa_sync  <= nxt_s.sa_sync;
      s_ff.cfg_sync <= nxt_s.cfg_sync;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Ready only while no response is pending: one write and one read at a time
  assign s_axi_awready      = !s_ff.aw_ok && !s_ff.bv;
  assign s_axi_wready       = !s_ff.w_ok && !s_ff.bv;
  assign s_axi_bvalid       = s_ff.bv;
  assign s_axi_bresp        = s_ff.br;
  assign s_axi_arready      = !s_ff.rv;
  assign s_axi_rvalid       = s_ff.rv;
  assign s_axi_rdata        = s_ff.rd;
  assign s_axi_rresp        = s_ff.rr;
  assign pwm_out            = s_ff.pwm;
  assign pwm_oe_out         = s_ff.oe;
  assign bus_address_out    = s_ff.addr;
  assign vout_target_out    = s_ff.vtgt;
  assign current_report_out = s_ff.irep;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  a_period_range: assert property (s_ff.period >= 10'(`PER_MIN) && s_ff.period <= 10'(`PER_MAX))
    else $error("period outside frequency range");
  a_one_drop: assert property (s_ff.act[0] < $past(s_ff.act[0]) |->
    s_ff.act[0] == $past(s_ff.act[0]) - 3'h1 || s_ff.act[0] == $past(have[0]))
    else $error("more than one phase dropped at once");
  a_min_phase: assert property (have[0] != 3'h0 |-> s_ff.act[0] != 3'h0)
    else $error("enabled rail left with no phase");
  a_fast_add: assert property (s_ff.ctrl[2] && reg_error_in > s_ff.fast_thr
    |=> s_ff.act[0] == $past(have[0]) && s_ff.act[1] == $past(have[1]))
    else $error("fast add did not restore all phases");
  a_drop_off: assert property (!s_ff.ctrl[2] |=> s_ff.act[1] == $past(have[1]))
    else $error("phase count moved with auto drop off");
  a_tgt_clamp: assert property ($past(s_ff.vmin[0]) <= $past(s_ff.vmax[0]) |->
    s_ff.vtgt[0] >= $past(s_ff.vmin[0]) && s_ff.vtgt[0] <= $past(s_ff.vmax[0]))
    else $error("target outside limits");
  a_strap_addr: assert property ($fell(s_ff.boot) |->
    s_ff.addr == 7'(`SA_TABLE >> (7 * $past(s_ff.sa_sync[2]))))
    else $error("address strap decoded wrongly");
  a_write_resp: assert property (s_ff.aw_ok && s_ff.w_ok |=> s_axi_bvalid)
    else $error("write not answered");
  a_refresh_low: assert property (s_ff.rwin != 8'h0 |=> (drop_q & s_ff.pwm) == 7'h0)
    else $error("refreshed phase driven high");

  // Dropped set one cycle late, aligned with the registered pwm it is checked against
  always_ff @(posedge clock_in) drop_q <= drop;
endmodule

// [core/phase_mgr_defs.svh]
// Constants for the seven-phase PWM phase manager.
// Assumes a 200 MHz core clock and a 32-bit AXI4-Lite register port.
`ifndef PHASE_MGR_DEFS_SVH
`define PHASE_MGR_DEFS_SVH
`define NPH            7
`define CLK_KHZ        200000
`define FSW_MIN_KHZ    200
`define FSW_MAX_KHZ    1000
`define PER_MAX        (`CLK_KHZ / `FSW_MIN_KHZ)
`define PER_MIN        (`CLK_KHZ / `FSW_MAX_KHZ)
`define TREF_C         25
`define TC_SHIFT       8
`define SLOPE_SHIFT    6
`define REFRESH_W      8'h28
`define MAP_RST        14'h007f
`define PER_RST        10'h1f4
`define DLY_RST        24'h030d40
`define REF_RST        24'h030d40
`define VMAX_RST       12'hfff
`define SA_TABLE       {7'h5d, 7'h5c, 7'h59, 7'h58, 7'h55, 7'h54, 7'h51, 7'h50, \
                        7'h45, 7'h44, 7'h41, 7'h40, 7'h65, 7'h64, 7'h61, 7'h60}
`define A_CTRL         8'h00
`define A_PERIOD       8'h04
`define A_MAP          8'h08
`define A_STORE        8'h0c
`define A_DUTY         8'h10
`define A_ADDTHR       8'h14
`define A_DROPTHR      8'h18
`define A_DROPDLY      8'h1c
`define A_FASTTHR      8'h20
`define A_REFRESH      8'h24
`define A_VCMD         8'h28
`define A_VMH          8'h2c
`define A_VML          8'h30
`define A_VMAX         8'h34
`define A_VMIN         8'h38
`define A_TCAL         8'h3c
`define A_STATUS       8'h40
`define RESP_OK        2'b00
`define RESP_SLVERR    2'b10
`endif

// [core/phase_mgr_pkg.sv]
// Types shared by the phase manager design and its bench.
// Assumes phase_mgr_defs.svh is on the include path.
package phase_mgr_pkg;
  typedef logic [11:0] word12_t;
  typedef logic [1:0][11:0] pair12_t;
  typedef struct packed {
    logic [2:0][3:0]  sa_sync;
    logic [2:0][2:0]  cfg_sync;
    logic             boot;
    logic [6:0]       addr;
    logic [2:0]       cfg_slot;
    logic [7:0][13:0] nvm;
    logic [13:0]      map;
    logic [3:0]       ctrl;
    logic [9:0]       period;
    logic [9:0]       cnt;
    logic [1:0][9:0]  duty;
    pair12_t          add_thr;
    pair12_t          drop_thr;
    pair12_t          vcmd;
    pair12_t          vmh;
    pair12_t          vml;
    pair12_t          vmax;
    pair12_t          vmin;
    pair12_t          vtgt;
    pair12_t          irep;
    logic [23:0]      drop_dly;
    logic [23:0]      refresh;
    word12_t          fast_thr;
    logic [15:0]      tcal;
    logic [1:0][2:0]  act;
    logic [1:0][23:0] dtmr;
    logic [23:0]      rtmr;
    logic [7:0]       rwin;
    logic [6:0]       pwm;
    logic [6:0]       oe;
    logic             aw_ok;
    logic             w_ok;
    logic [7:0]       awa;
    logic [31:0]      wd;
    logic [3:0]       ws;
    logic             bv;
    logic [1:0]       br;
    logic             rv;
    logic [31:0]      rd;
    logic [1:0]       rr;
  } st_s;
endpackage

// [tb/power_stage_model.sv]
// Model of the power stages: switch states of one watched phase, phase 0 timing.
// Assumes the controller drives pwm and enable on the same clock.
`timescale 1ns/1ps
module power_stage_model #(
  parameter int WATCH = 3
) (
  input  wire logic       clock_in,
  input  wire logic       clr_in,
  input  wire logic [6:0] pwm_in,
  input  wire logic [6:0] oe_in,
  output int              hs_out,
  output int              ls_out,
  output int              per_out,
  output int              wid_out
);
  int   t;
  int   rise;
  logic hi0;
  // Driven high turns the high side on, driven low the low side; released leaves both off
  always @(posedge clock_in) begin
    t <= t + 1;
    hi0 <= oe_in[0] & pwm_in[0];
    if (oe_in[0] & pwm_in[0] & !hi0) begin
      per_out <= t - rise;
      rise <= t;
    end
    if (!(oe_in[0] & pwm_in[0]) & hi0) begin
      wid_out <= t - rise;
    end
    hs_out <= clr_in ? 0 : hs_out + int'(oe_in[WATCH] & pwm_in[WATCH]);
    ls_out <= clr_in ? 0 : ls_out + int'(oe_in[WATCH] & !pwm_in[WATCH]);
  end
endmodule

// [tb/tb_multiphase_pwm_phase_manager.sv]
// Self-checking bench for the seven-phase PWM phase manager.
// Assumes the design, its package and the power stage model are compiled first.
`timescale 1ns/1ps
`include "phase_mgr_defs.svh"
module tb_multiphase_pwm_phase_manager;
  import phase_mgr_pkg::*;
  logic            clock_in, rst_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic            s_axi_arvalid, s_axi_rready, avs_valid_in, avs_rail_in, clr;
  logic            s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]      s_axi_awaddr, s_axi_araddr;
  logic [31:0]     s_axi_wdata, s_axi_rdata, d;
  logic [3:0]      s_axi_wstrb, address_strap_pin, margin_sel_in;
  logic [1:0]      s_axi_bresp, s_axi_rresp, r;
  logic [2:0]      config_strap_in;
  logic [6:0]      pwm_out, pwm_oe_out, bus_address_out;
  logic [1:0][7:0] lead_adj_in, trail_adj_in;
  pair12_t         load_current_in, sense_temp_in, vout_target_out, current_report_out;
  word12_t         reg_error_in, avs_vout_in;
  int              fail_count, checked, cyc, dt, v, hs3, ls3, per, wid, mark;
  logic [6:0]      atbl [16] = '{7'h60, 7'h61, 7'h64, 7'h65, 7'h40, 7'h41, 7'h44, 7'h45,
                                 7'h50, 7'h51, 7'h54, 7'h55, 7'h58, 7'h59, 7'h5c, 7'h5d};

  phase_mgr dut (.clock_in, .rst_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .address_strap_pin, .config_strap_in,
    .load_current_in, .sense_temp_in, .reg_error_in, .lead_adj_in, .trail_adj_in,
    .margin_sel_in, .avs_valid_in, .avs_rail_in, .avs_vout_in, .pwm_out, .pwm_oe_out,
    .bus_address_out, .vout_target_out, .current_report_out);
  power_stage_model stages (.clock_in, .clr_in(clr), .pwm_in(pwm_out), .oe_in(pwm_oe_out),
    .hs_out(hs3), .ls_out(ls3), .per_out(per), .wid_out(wid));

  // Clock and a free cycle count for latency measurements
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  always @(posedge clock_in) cyc <= cyc + 1;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  // A used-up wait bound counts as a mismatch and ends the run
  task automatic tmo(input int n);
    if (n >= 80) begin
      fail_count++;
      wrap_up();
    end
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 80);
    s_axi_bready <= 1'b0;
    tick(1);
    tmo(n);
  endtask

  task automatic axr(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 80);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tick(1);
    tmo(n);
  endtask

  // Poll the status word until rail 0 shows the given phase count
  // Spacing is measured from the previous mark, so later waits do not hide it
  task automatic wait_act(input logic [2:0] e);
    int n;
    n = 0;
    do begin
      axr(`A_STATUS);
      n++;
    end while (d[2:0] !== e && n < 80);
    dt = cyc - mark;
    mark = cyc;
    tmo(n);
  endtask

  // Enables outside a refresh window show only the active phases
  task automatic wait_oe(input logic [6:0] e);
    int n;
    for (n = 0; n < 80 && pwm_oe_out !== e; n++) @(posedge clock_in);
    chk(pwm_oe_out, e);
  endtask

  function automatic logic [11:0] clampv(int x);
    return 12'(x < 'h100 ? 'h100 : (x > 'h800 ? 'h800 : x));
  endfunction

  initial begin
    {rst_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
    {avs_valid_in, avs_rail_in, clr, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {address_strap_pin, margin_sel_in, config_strap_in, load_current_in, sense_temp_in} = '0;
    {lead_adj_in, trail_adj_in, reg_error_in, avs_vout_in} = '0;
    s_axi_wstrb = 4'hf;
    v = $urandom(32'h8c2c9fc2);
    // Straps are sampled only after a reset, so each code gets its own
    for (int k = 0; k < 16; k++) begin
      address_strap_pin <= k[3:0];
      config_strap_in <= k[2:0];
      rst_in <= 1'b1;
      tick(k == 0 ? 20 : 3);
      rst_in <= 1'b0;
      tick(6);
      chk(bus_address_out, atbl[k]);
      axr(`A_STATUS);
      chk({d[17:15], d[14:8]}, {k[2:0], atbl[k]});
    end
    axr(`A_MAP);
    chk({r, d}, {2'b00, 32'h7f});
    axr(8'h44);
    chk({r, d}, {2'b10, 32'h0});
    axw(`A_PERIOD, 32'd100);
    axr(`A_PERIOD);
    chk(d, 32'd200);
    axw(`A_PERIOD, 32'h3ff);
    axr(`A_PERIOD);
    chk(d, 32'd1000);
    axw(`A_PERIOD, 32'd200);
    axw(`A_DUTY, 32'd50);
    lead_adj_in <= {8'd0, 8'd3};
    trail_adj_in <= {8'd0, 8'd2};
    tick(700);
    chk(per, 200);
    chk(wid, 55);
    tick(200);
    chk(per, 200);
    axw(`A_VMAX, 32'h0800_0800);
    axw(`A_VMIN, 32'h0100_0100);
    axw(`A_VMH, 32'h0000_0600);
    axw(`A_VML, 32'h0000_0020);
    axw(`A_VCMD, 32'h0900_0050);
    tick(2);
    chk(vout_target_out, {12'h800, 12'h100});
    margin_sel_in <= 4'h1;
    tick(3);
    chk(vout_target_out[0], 12'h600);
    margin_sel_in <= 4'h2;
    tick(3);
    chk(vout_target_out[0], 12'h100);
    margin_sel_in <= 4'h0;
    v = $urandom_range(4095, 0);
    avs_vout_in <= v[11:0];
    avs_rail_in <= 1'b1;
    avs_valid_in <= 1'b1;
    tick(1);
    avs_valid_in <= 1'b0;
    tick(3);
    chk(vout_target_out[1], clampv(v));
    axw(`A_TCAL, 32'h40);
    axw(`A_CTRL, 32'h9);
    v = $urandom_range(4095, 0) & 'hffe;
    load_current_in <= {12'h321, v[11:0]};
    sense_temp_in <= {12'd25, 12'd153};
    tick(4);
    chk(current_report_out, {12'h321, 12'(v - v * 128 / 256)});
    // Rail 0 owns phases 0-3, rail 1 phases 6, 5, 4
    axw(`A_MAP, 32'h387f);
    axw(`A_DROPDLY, 32'd60);
    axw(`A_REFRESH, 32'd100);
    axw(`A_ADDTHR, 32'h0f00_0f00);
    axw(`A_DROPTHR, 32'h0200_0200);
    axw(`A_FASTTHR, 32'h100);
    load_current_in <= {12'h800, 12'h800};
    axw(`A_CTRL, 32'h3);
    axw(`A_CTRL, 32'h7);
    axr(`A_STATUS);
    chk(d[6:0], 7'h34);
    load_current_in <= {12'h100, 12'h100};
    mark = cyc;
    wait_act(3'd3);
    chk(dt >= 60 && dt <= 68, 1'b1);
    chk(d[6:0], 7'h23);
    wait_oe(7'h67);
    wait_act(3'd2);
    chk(dt >= 56 && dt <= 70, 1'b1);
    wait_oe(7'h43);
    tick(250);
    axr(`A_STATUS);
    chk(d[6:0], 7'h11);
    clr <= 1'b1;
    tick(1);
    clr <= 1'b0;
    tick(303);
    chk(hs3, 0);
    chk(ls3 >= 80 && ls3 <= 125, 1'b1);
    load_current_in <= {12'hf80, 12'hf80};
    tick(8);
    axr(`A_STATUS);
    chk(d[6:0], 7'h34);
    load_current_in <= {12'h100, 12'h100};
    wait_act(3'd1);
    reg_error_in <= 12'h200;
    tick(2);
    axr(`A_STATUS);
    chk(d[6:0], 7'h34);
    wrap_up();
  end
endmodule
